// ### tcc_pkg.sv
package tcc_pkg;
	// axi4-lite register map, one aligned word each, data in bits 7:0
	localparam int AXI_AW = 8;
	localparam logic [7:0] OFS_CTRL_A = 8'h00;
	localparam logic [7:0] OFS_CTRL_B = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_CMP_A = 8'h0C;
	localparam logic [7:0] OFS_CMP_B = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_FLAG = 8'h18;
	localparam logic [7:0] REG_RST = 8'h00;

	// timer_control_a fields
	localparam int CTA_COMA_LSB = 6;
	localparam int CTA_COMB_LSB = 4;
	localparam int CTA_WGM_LSB = 0;
	// timer_control_b fields
	localparam int CTB_FOCA = 7;
	localparam int CTB_FOCB = 6;
	localparam int CTB_WGM2 = 3;
	localparam int CTB_CS_LSB = 0;
	// flag and mask bit positions
	localparam int FLG_OVF = 0;
	localparam int FLG_CMPA = 1;
	localparam int FLG_CMPB = 2;

	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;

	// waveform modes; 4 and 6 are reserved and run as normal
	localparam logic [2:0] WGM_NORMAL = 3'h0;
	localparam logic [2:0] WGM_PC_MAX = 3'h1;
	localparam logic [2:0] WGM_CTC = 3'h2;
	localparam logic [2:0] WGM_FAST_MAX = 3'h3;
	localparam logic [2:0] WGM_PC_CMPA = 3'h5;
	localparam logic [2:0] WGM_FAST_CMPA = 3'h7;

	// clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam logic [9:0] PRE_MASK8 = 10'h007;
	localparam logic [9:0] PRE_MASK64 = 10'h03F;
	localparam logic [9:0] PRE_MASK256 = 10'h0FF;
	localparam logic [9:0] PRE_MASK1024 = 10'h3FF;

	// compare output mode actions
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### tcc_top.sv
`timescale 1ns/100ps
module tcc_top (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic external_count_pin_i,
	input wire logic irq_ack_ovf_i,
	input wire logic irq_ack_cmpa_i,
	input wire logic irq_ack_cmpb_i,
	output logic irq_ovf_o,
	output logic irq_cmpa_o,
	output logic irq_cmpb_o,
	output logic compare_output_a_o,
	output logic compare_output_b_o,
	output logic compare_output_a_en_o,
	output logic compare_output_b_en_o
);

	////////////////////////////////////////////////////////////////////////////
	// state
	logic [7:0] timer_control_a;
	logic [7:0] timer_control_b;
	logic [7:0] count_value;
	logic [7:0] compare_value_a;
	logic [7:0] compare_value_b;
	logic [7:0] cmp_buf_a;
	logic [7:0] cmp_buf_b;
	logic [2:0] timer_mask_reg;
	logic [2:0] timer_flag_reg;
	logic count_down;
	logic match_block;
	logic oc_a;
	logic oc_b;
	logic [9:0] prescale;
	logic ext_prev;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	////////////////////////////////////////////////////////////////////////////
	// register bus decode
	wire wr_en = aw_held & w_held & ~s_axi_bvalid_o;
	wire wr_low = wr_en & w_strb[0];
	wire [7:0] wr_byte = w_data[7:0];
	wire wr_hit_cta = aw_addr == tcc_pkg::OFS_CTRL_A;
	wire wr_hit_ctb = aw_addr == tcc_pkg::OFS_CTRL_B;
	wire wr_hit_cnt = aw_addr == tcc_pkg::OFS_COUNT;
	wire wr_hit_ca = aw_addr == tcc_pkg::OFS_CMP_A;
	wire wr_hit_cb = aw_addr == tcc_pkg::OFS_CMP_B;
	wire wr_hit_msk = aw_addr == tcc_pkg::OFS_MASK;
	wire wr_hit_flg = aw_addr == tcc_pkg::OFS_FLAG;
	wire wr_mapped = wr_hit_cta | wr_hit_ctb | wr_hit_cnt | wr_hit_ca | wr_hit_cb | wr_hit_msk | wr_hit_flg;
	wire cnt_wr = wr_low & wr_hit_cnt;
	wire ar_take = s_axi_arvalid_i & s_axi_arready_o;

	////////////////////////////////////////////////////////////////////////////
	// mode decode
	wire [2:0] waveform_mode = {timer_control_b[tcc_pkg::CTB_WGM2],
		timer_control_a[tcc_pkg::CTA_WGM_LSB +: 2]};
	wire [2:0] clock_select = timer_control_b[tcc_pkg::CTB_CS_LSB +: 3];
	wire [1:0] com_a = timer_control_a[tcc_pkg::CTA_COMA_LSB +: 2];
	wire [1:0] com_b = timer_control_a[tcc_pkg::CTA_COMB_LSB +: 2];
	wire mode_fast = waveform_mode == tcc_pkg::WGM_FAST_MAX || waveform_mode == tcc_pkg::WGM_FAST_CMPA;
	wire mode_phase = waveform_mode == tcc_pkg::WGM_PC_MAX || waveform_mode == tcc_pkg::WGM_PC_CMPA;
	wire mode_ctc = waveform_mode == tcc_pkg::WGM_CTC;
	wire mode_pwm = mode_fast | mode_phase;
	wire top_is_cmpa = mode_ctc || waveform_mode == tcc_pkg::WGM_PC_CMPA
		|| waveform_mode == tcc_pkg::WGM_FAST_CMPA;
	wire [7:0] top_value = top_is_cmpa ? compare_value_a : tcc_pkg::CNT_MAX;
	wire at_top = count_value == top_value;
	wire at_bottom = count_value == tcc_pkg::CNT_BOTTOM;
	wire at_max = count_value == tcc_pkg::CNT_MAX;

	////////////////////////////////////////////////////////////////////////////
	// clock select: free running prescaler or external pin edge
	wire ext_rise = ~ext_prev & external_count_pin_i;
	wire ext_fall = ext_prev & ~external_count_pin_i;
	logic timer_tick;
	always_comb begin
		unique case (clock_select)
			tcc_pkg::CS_STOP: timer_tick = 1'b0;
			tcc_pkg::CS_DIV1: timer_tick = 1'b1;
			tcc_pkg::CS_DIV8: timer_tick = (prescale & tcc_pkg::PRE_MASK8) == tcc_pkg::PRE_MASK8;
			tcc_pkg::CS_DIV64: timer_tick = (prescale & tcc_pkg::PRE_MASK64) == tcc_pkg::PRE_MASK64;
			tcc_pkg::CS_DIV256: timer_tick = (prescale & tcc_pkg::PRE_MASK256) == tcc_pkg::PRE_MASK256;
			tcc_pkg::CS_DIV1024: timer_tick = prescale == tcc_pkg::PRE_MASK1024;
			tcc_pkg::CS_EXT_FALL: timer_tick = ext_fall;
			tcc_pkg::CS_EXT_RISE: timer_tick = ext_rise;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// counter unit
	wire tick_run = timer_tick & ~cnt_wr;
	logic [7:0] next_count_value;
	logic next_count_down;
	always_comb begin
		next_count_value = count_value;
		next_count_down = count_down;
		if (cnt_wr) begin
			next_count_value = wr_byte;
		end else if (timer_tick) begin
			if (mode_phase) begin
				if (!count_down && at_top) begin
					next_count_down = 1'b1;
					next_count_value = count_value - 8'h01;
				end else if (count_down && at_bottom) begin
					next_count_down = 1'b0;
					next_count_value = count_value + 8'h01;
				end else if (count_down) begin
					next_count_value = count_value - 8'h01;
				end else begin
					next_count_value = count_value + 8'h01;
				end
			end else if ((mode_fast || mode_ctc) && at_top) begin
				next_count_value = tcc_pkg::CNT_BOTTOM;
			end else begin
				next_count_value = count_value + 8'h01;
			end
		end
		if (!mode_phase) begin
			next_count_down = 1'b0;
		end
	end

	// overflow position: wrap from max in normal/ctc, top in fast pwm, bottom in phase correct
	wire ovf_set = tick_run & (mode_fast ? at_top : mode_phase ? (at_bottom & count_down) : at_max);

	////////////////////////////////////////////////////////////////////////////
	// output compare units
	wire match_a = count_value == compare_value_a;
	wire match_b = count_value == compare_value_b;
	wire hit_a = tick_run & match_a & ~match_block;
	wire hit_b = tick_run & match_b & ~match_block;
	// double buffered update: bottom of fast pwm, top of phase correct
	wire buf_load = tick_run & at_top & (mode_fast | (mode_phase & ~count_down));
	wire foc_a = wr_low & wr_hit_ctb & wr_byte[tcc_pkg::CTB_FOCA] & ~mode_pwm;
	wire foc_b = wr_low & wr_hit_ctb & wr_byte[tcc_pkg::CTB_FOCB] & ~mode_pwm;
	wire fast_bottom = tick_run & mode_fast & at_top;

	// oc state update; com bits are read live so a change acts on the next event
	function automatic logic oc_step(input logic oc, input logic [1:0] com, input logic hit,
		input logic frc, input logic bot, input logic fast, input logic phase, input logic down);
		logic r;
		r = oc;
		if (fast) begin
			// bottom first so compare==top leaves a full-width pulse
			if (bot && com == tcc_pkg::COM_CLEAR) begin
				r = 1'b1;
			end else if (bot && com == tcc_pkg::COM_SET) begin
				r = 1'b0;
			end else if (hit && com == tcc_pkg::COM_CLEAR) begin
				r = 1'b0;
			end else if (hit && com == tcc_pkg::COM_SET) begin
				r = 1'b1;
			end
		end else if (phase) begin
			if (hit && com[1]) begin
				r = down ^ com[0];
			end
		end else if (hit || frc) begin
			unique case (com)
				tcc_pkg::COM_OFF: r = oc;
				tcc_pkg::COM_TOGGLE: r = ~oc;
				tcc_pkg::COM_CLEAR: r = 1'b0;
				tcc_pkg::COM_SET: r = 1'b1;
			endcase
		end
		return r;
	endfunction

	wire next_oc_a = oc_step(oc_a, com_a, hit_a, foc_a, fast_bottom, mode_fast, mode_phase, count_down);
	wire next_oc_b = oc_step(oc_b, com_b, hit_b, foc_b, fast_bottom, mode_fast, mode_phase, count_down);

	////////////////////////////////////////////////////////////////////////////
	// flags: set wins over any clear in the same cycle
	wire [2:0] flag_set = {hit_b, hit_a, ovf_set};
	wire [2:0] flag_sw_clr = (wr_low & wr_hit_flg) ? wr_byte[2:0] : 3'h0;
	wire [2:0] flag_ack = {irq_ack_cmpb_i, irq_ack_cmpa_i, irq_ack_ovf_i};
	wire [2:0] next_flag = (timer_flag_reg & ~(flag_sw_clr | flag_ack)) | flag_set;
	wire [2:0] irq_req = next_flag & timer_mask_reg;

	////////////////////////////////////////////////////////////////////////////
	// read mux; compare reads see the buffer, which a write made outside pwm also copies to active
	logic [7:0] rd_byte;
	logic rd_ok;
	always_comb begin
		rd_byte = tcc_pkg::REG_RST;
		rd_ok = 1'b1;
		unique case (s_axi_araddr_i)
			tcc_pkg::OFS_CTRL_A: rd_byte = timer_control_a;
			tcc_pkg::OFS_CTRL_B: rd_byte = {2'h0, timer_control_b[5:0]};
			tcc_pkg::OFS_COUNT: rd_byte = count_value;
			tcc_pkg::OFS_CMP_A: rd_byte = cmp_buf_a;
			tcc_pkg::OFS_CMP_B: rd_byte = cmp_buf_b;
			tcc_pkg::OFS_MASK: rd_byte = {5'h00, timer_mask_reg};
			tcc_pkg::OFS_FLAG: rd_byte = {5'h00, timer_flag_reg};
			default: rd_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave handshakes
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= tcc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_en) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_mapped ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= tcc_pkg::RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= {24'h00_0000, rd_byte};
			s_axi_rresp_o <= rd_ok ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers; force bits are strobes and never stored
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			timer_control_a <= tcc_pkg::REG_RST;
			timer_control_b <= tcc_pkg::REG_RST;
			timer_mask_reg <= 3'h0;
		end else begin
			if (wr_low && wr_hit_cta) begin
				timer_control_a <= wr_byte;
			end
			if (wr_low && wr_hit_ctb) begin
				timer_control_b <= {2'h0, wr_byte[5:0]};
			end
			if (wr_low && wr_hit_msk) begin
				timer_mask_reg <= wr_byte[2:0];
			end
		end
	end

	// compare values: buffer always takes the write, active only when unbuffered
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cmp_buf_a <= tcc_pkg::REG_RST;
			cmp_buf_b <= tcc_pkg::REG_RST;
			compare_value_a <= tcc_pkg::REG_RST;
			compare_value_b <= tcc_pkg::REG_RST;
		end else begin
			if (wr_low && wr_hit_ca) begin
				cmp_buf_a <= wr_byte;
			end
			if (wr_low && wr_hit_cb) begin
				cmp_buf_b <= wr_byte;
			end
			if (wr_low && wr_hit_ca && !mode_pwm) begin
				compare_value_a <= wr_byte;
			end else if (mode_pwm && buf_load) begin
				compare_value_a <= cmp_buf_a;
			end
			if (wr_low && wr_hit_cb && !mode_pwm) begin
				compare_value_b <= wr_byte;
			end else if (mode_pwm && buf_load) begin
				compare_value_b <= cmp_buf_b;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// counter, blocking, prescaler, outputs
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			count_value <= tcc_pkg::CNT_BOTTOM;
			count_down <= 1'b0;
			match_block <= 1'b0;
			prescale <= 10'h000;
			ext_prev <= 1'b0;
		end else begin
			count_value <= next_count_value;
			count_down <= next_count_down;
			prescale <= prescale + 10'h001;
			ext_prev <= external_count_pin_i;
			// block holds until a tick consumes it, so a stopped timer still sees it
			if (cnt_wr) begin
				match_block <= 1'b1;
			end else if (timer_tick) begin
				match_block <= 1'b0;
			end
		end
	end

	// oc states are untouched by a mode write; only events move them
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			oc_a <= 1'b0;
			oc_b <= 1'b0;
			timer_flag_reg <= 3'h0;
			irq_ovf_o <= 1'b0;
			irq_cmpa_o <= 1'b0;
			irq_cmpb_o <= 1'b0;
			compare_output_a_o <= 1'b0;
			compare_output_b_o <= 1'b0;
			compare_output_a_en_o <= 1'b0;
			compare_output_b_en_o <= 1'b0;
		end else begin
			oc_a <= next_oc_a;
			oc_b <= next_oc_b;
			timer_flag_reg <= next_flag;
			irq_ovf_o <= irq_req[tcc_pkg::FLG_OVF];
			irq_cmpa_o <= irq_req[tcc_pkg::FLG_CMPA];
			irq_cmpb_o <= irq_req[tcc_pkg::FLG_CMPB];
			compare_output_a_o <= next_oc_a;
			compare_output_b_o <= next_oc_b;
			compare_output_a_en_o <= |com_a;
			compare_output_b_en_o <= |com_b;
		end
	end

endmodule

// ### tcc_assertions.sv
`timescale 1ns/100ps
module tcc_assertions (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic irq_ack_cmpa_i,
	input wire logic irq_cmpa_o,
	input wire logic compare_output_a_en_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////
	property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
	a_rhold: assert property (p_rhold) else $error("read response not held");
	property p_rupper; s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000; endproperty
	a_rupper: assert property (p_rupper) else $error("read data wider than a byte");
	property p_wbusy; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
	a_wbusy: assert property (p_wbusy) else $error("write accepted during response");
	property p_wlat; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
		|=> !s_axi_bvalid_o ##1 s_axi_bvalid_o; endproperty
	a_wlat: assert property (p_wlat) else $error("write response latency wrong");
	property p_rlat; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o; endproperty
	a_rlat: assert property (p_rlat) else $error("read response latency wrong");
	property p_rerr; s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > tcc_pkg::OFS_FLAG
		|=> s_axi_rresp_o == tcc_pkg::RESP_SLVERR; endproperty
	a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
	// a flag only drops by acknowledge or by a software write
	property p_irqfall; $fell(irq_cmpa_o) |-> $past(irq_ack_cmpa_i) || $past(irq_ack_cmpa_i, 2)
		|| s_axi_bvalid_o || $past(s_axi_bvalid_o); endproperty
	a_irqfall: assert property (p_irqfall) else $error("compare a request dropped without cause");
	property p_oen; $changed(compare_output_a_en_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o); endproperty
	a_oen: assert property (p_oen) else $error("output enable changed without a write");
endmodule
////////////////////////////////////////////////////////////
bind tcc_top tcc_assertions u_chk (
	.sys_clk_i(sys_clk_i),
	.sys_rst_i(sys_rst_i),
	.s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i),
	.s_axi_araddr_i(s_axi_araddr_i),
	.s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rresp_o(s_axi_rresp_o),
	.s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i),
	.irq_ack_cmpa_i(irq_ack_cmpa_i),
	.irq_cmpa_o(irq_cmpa_o),
	.compare_output_a_en_o(compare_output_a_en_o)
);

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [3:0] s; logic [7:0] q; logic [1:0] r;} tcc_row_t;
	logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic pin = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0] wstrb = 4'hF;
	logic [2:0] ack = 3'h0;
	wire [2:0] irq;
	logic [1:0] bresp, rresp, resp;
	wire [1:0] oc, oen;
	int bad_count = 0, samples_checked = 0;
	tcc_row_t rows [9] = '{'{tcc_pkg::OFS_MASK, 8'h07, 4'hF, 8'h07, 2'h0}, '{tcc_pkg::OFS_MASK, 8'h05, 4'h0, 8'h07, 2'h0},
		'{tcc_pkg::OFS_MASK, 8'h00, 4'hF, 8'h00, 2'h0}, '{tcc_pkg::OFS_CMP_A, 8'h5A, 4'hF, 8'h5A, 2'h0},
		'{tcc_pkg::OFS_CMP_B, 8'hA5, 4'hF, 8'hA5, 2'h0}, '{tcc_pkg::OFS_COUNT, 8'h3C, 4'hF, 8'h3C, 2'h0},
		'{tcc_pkg::OFS_CTRL_B, 8'hC0, 4'hF, 8'h00, 2'h0}, '{8'h1C, 8'h11, 4'hF, 8'h00, 2'h2},
		'{8'hFC, 8'h22, 4'hF, 8'h00, 2'h2}};
	// ctrl_a, start count, ctrl_b, pin pulses, expected count
	logic [39:0] ext [8] = '{40'h00_00_07_03_03, 40'h00_03_06_02_05, 40'h00_05_00_02_05,
		40'h01_FE_07_03_FD, 40'h02_00_07_04_01, 40'h03_FE_07_03_01, 40'h03_00_0F_04_01, 40'h01_00_0F_05_01};
	// idle cycles per divider; the two control writes add four more edges, so any prescaler phase gives whole ticks
	int pre_n [4] = '{32'h3C, 32'h1FC, 32'h7FC, 32'hFFC};
	logic [7:0] pre_q [4] = '{8'h08, 8'h08, 8'h08, 8'h04};
	always #5 clk = ~clk;
	tcc_top DUT (.sys_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .external_count_pin_i(pin),
		.irq_ack_ovf_i(ack[0]), .irq_ack_cmpa_i(ack[1]), .irq_ack_cmpb_i(ack[2]), .irq_ovf_o(irq[0]),
		.irq_cmpa_o(irq[1]), .irq_cmpb_o(irq[2]), .compare_output_a_o(oc[0]), .compare_output_b_o(oc[1]),
		.compare_output_a_en_o(oen[0]), .compare_output_b_en_o(oen[1]));
	////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// every task starts and ends just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid === 1'b1) && n < 40);
		resp = bresp;
		bready <= 1'b0;
		if (n >= 40) chk("write timeout", 32'h1, 32'h0);
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid === 1'b1) && n < 40);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n >= 40) chk("read timeout", 32'h1, 32'h0);
		chk(nm, {24'h0, exp}, rd);
		@(posedge clk);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_sim();
	end
	initial begin
		cyc(4);
		rst <= 1'b0;
		cyc(1);
		for (int i = 0; i < 9; i++) begin
			wr(rows[i].a, rows[i].d, rows[i].s);
			chk("bresp", {30'h0, rows[i].r}, {30'h0, resp});
			rdchk(rows[i].a, rows[i].q, "row read");
			chk("rresp", {30'h0, rows[i].r}, {30'h0, resp});
		end
		wr(tcc_pkg::OFS_COUNT, 8'h10);
		wr(tcc_pkg::OFS_CMP_A, 8'h10);
		wr(tcc_pkg::OFS_MASK, 8'h07);
		wr(tcc_pkg::OFS_CTRL_B, 8'h01);
		rdchk(tcc_pkg::OFS_FLAG, 8'h00, "blocked match");
		cyc(270);
		rdchk(tcc_pkg::OFS_FLAG, 8'h07, "flags after wrap");
		chk("irq all", 32'h7, {29'h0, irq});
		wr(tcc_pkg::OFS_CTRL_B, 8'h00);
		wr(tcc_pkg::OFS_FLAG, 8'h00);
		rdchk(tcc_pkg::OFS_FLAG, 8'h07, "zero write");
		wr(tcc_pkg::OFS_FLAG, 8'h02);
		rdchk(tcc_pkg::OFS_FLAG, 8'h05, "one clears");
		chk("irq after clear", 32'h5, {29'h0, irq});
		wr(tcc_pkg::OFS_MASK, 8'h03);
		chk("irq masked", 32'h1, {29'h0, irq});
		ack <= 3'h7;
		cyc(1);
		ack <= 3'h0;
		cyc(2);
		rdchk(tcc_pkg::OFS_FLAG, 8'h00, "ack clears");
		wr(tcc_pkg::OFS_CTRL_A, 8'h70);
		chk("output enables", 32'h3, {30'h0, oen});
		wr(tcc_pkg::OFS_CTRL_B, 8'hC0);
		chk("force both", 32'h3, {30'h0, oc});
		wr(tcc_pkg::OFS_CTRL_B, 8'h80);
		chk("force toggle", 32'h2, {30'h0, oc});
		rdchk(tcc_pkg::OFS_FLAG, 8'h00, "force no flag");
		wr(tcc_pkg::OFS_CTRL_A, 8'h73);
		chk("mode change", 32'h2, {30'h0, oc});
		// fast pwm: the new compare value must wait in the buffer, the old one still matches
		wr(tcc_pkg::OFS_COUNT, 8'h0F);
		wr(tcc_pkg::OFS_CMP_A, 8'h20);
		rdchk(tcc_pkg::OFS_CMP_A, 8'h20, "buffer read");
		wr(tcc_pkg::OFS_CTRL_B, 8'h01);
		wr(tcc_pkg::OFS_CTRL_B, 8'h00);
		rdchk(tcc_pkg::OFS_FLAG, 8'h02, "buffered match");
		for (int i = 0; i < 8; i++) begin
			wr(tcc_pkg::OFS_CTRL_A, ext[i][39:32]);
			wr(tcc_pkg::OFS_CMP_A, 8'h02);
			wr(tcc_pkg::OFS_COUNT, ext[i][31:24]);
			wr(tcc_pkg::OFS_CTRL_B, ext[i][23:16]);
			repeat (ext[i][15:8]) begin
				pin <= 1'b1;
				cyc(3);
				pin <= 1'b0;
				cyc(3);
			end
			wr(tcc_pkg::OFS_CTRL_B, 8'h00);
			rdchk(tcc_pkg::OFS_COUNT, ext[i][7:0], "pin count");
		end
		for (int i = 0; i < 4; i++) begin
			wr(tcc_pkg::OFS_COUNT, 8'h00);
			wr(tcc_pkg::OFS_CTRL_B, 8'(i) + 8'h02);
			cyc(pre_n[i]);
			wr(tcc_pkg::OFS_CTRL_B, 8'h00);
			rdchk(tcc_pkg::OFS_COUNT, pre_q[i], "prescaled count");
		end
		rst <= 1'b1;
		cyc(4);
		rst <= 1'b0;
		cyc(1);
		for (int a = 0; a <= 24; a += 4) rdchk(8'(a), tcc_pkg::REG_RST, "reset value");
		chk("reset outputs", 32'h0, {25'h0, irq, oc, oen});
		end_sim();
	end
endmodule
